// ===== verilog/ldm_map.svh
`ifndef LDM_MAP_SVH
`define LDM_MAP_SVH

// register word offsets on the plain register port
`define LDM_REG_STATUS 4'h0
`define LDM_REG_CTRL 4'h1
`define LDM_REG_IRQ_STAT 4'h2
`define LDM_REG_IRQ_MASK 4'h3

// status register fields
`define LDM_ST_STATE_LSB 0
`define LDM_ST_FAIL_LSB 4
`define LDM_ST_BOOST_LSB 6
`define LDM_ST_SWITCH_LSB 8

// control register fields and reset value
`define LDM_CTRL_OT_AUTO 0
`define LDM_CTRL_RESET 32'h0000_0000

// interrupt event bits
`define LDM_IRQ_FAIL0 0
`define LDM_IRQ_FAIL1 1
`define LDM_IRQ_OV 2
`define LDM_IRQ_OT 3
`define LDM_IRQ_STANDBY 4
`define LDM_IRQ_SHUTDOWN 5
`define LDM_IRQ_W 6
`define LDM_IRQ_MASK_RESET 6'h00

// qualification counts in device clock cycles
`define LDM_ON_QUAL_CYCLES 64
`define LDM_OFF_QUAL_CYCLES 64
`define LDM_QUAL_CNT_W 12

`endif

// ===== verilog/ldm_pkg.sv
package ldm_pkg;

    // global operating states
    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_ON,
        ST_LOW_V,
        ST_OVERVOLT,
        ST_OVERTEMP,
        ST_SHUTDOWN
    } ldm_state_t;

    // comparator flags and dimming pins, all asynchronous to the clock
    typedef struct packed {
        logic [1:0] dimming_input;
        logic supply_below_4v;
        logic supply_below_3v5;
        logic supply_above_6v;
        logic supply_above_40v;
        logic temp_above_165c;
        logic temp_below_145c;
        logic [1:0] vout_low;
        logic [1:0] sense_cm_low;
        logic [1:0] sense_short;
        logic [1:0] open_load;
    } ldm_flags_t;

    // per-channel drive to the analog side, plus the shared regulator enable
    typedef struct packed {
        logic [1:0] dim_switch_on;
        logic [1:0] boost_en;
        logic [1:0] comp_hold;
        logic [1:0] comp_clear;
        logic [1:0] diag_drive_high;
        logic [1:0] diag_drive_low;
        logic vreg_en;
    } ldm_drive_t;

endpackage

// ===== verilog/ldm_fsm.sv
// Function
// - each dimming switch follows its channel's dimming input frequency and duty.
// - switch off freezes that channel's control loop, holding compensation value.
// - each on-time resumes loop from held compensation, never from reset.
// - supply below 4 V in normal operation disables healthy boost controllers.
// - above 3.5 V in low-voltage state, switches follow inputs, regulator on.
// - supply back above 4 V re-enables controllers that were healthy before.
// - supply below 3.5 V enters standby for battery undervoltage.
// - standby exits only with supply above 6 V and an input qualified high.
// - supply above 40 V disables both controllers, switches off, regulator on.
// - overvoltage recovery needs supply below 40 V, then global off-on cycle.
// - temperature above 165 C disables both controllers and both switches.
// - overtemperature recovery only below 145 C, automatic or cycle by control.
// - channel fails on low output, low sense common mode, or shorted output.
// - open load pulls diagnostic low while channel keeps operating normally.
// - channel failure turns switch off, diagnostic high, latched until channel cycle.
// - global shutdown after both inputs qualified low drives both diagnostics low.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`include "ldm_map.svh"

module ldm_fsm #(
    parameter int N_CH = 2,
    parameter int CNT_W = `LDM_QUAL_CNT_W,
    parameter int ON_QUAL = `LDM_ON_QUAL_CYCLES,
    parameter int OFF_QUAL = `LDM_OFF_QUAL_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire ldm_pkg::ldm_flags_t i_flags,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output ldm_pkg::ldm_drive_t o_drive
);

    // elaboration-time checks on the parameters
    if (N_CH < 1 || N_CH > 2) begin : g_bad_nch
        $error("N_CH must be 1 or 2");
    end
    // the counter saturates at all ones, so a count must sit strictly below that
    if (ON_QUAL < 1 || OFF_QUAL < 1 ||
        ON_QUAL >= 2**CNT_W - 1 || OFF_QUAL >= 2**CNT_W - 1) begin : g_bad_q
        $error("qualification counts do not fit CNT_W");
    end

    localparam logic [CNT_W-1:0] ON_Q = CNT_W'(ON_QUAL);
    localparam logic [CNT_W-1:0] OFF_Q = CNT_W'(OFF_QUAL);
    localparam logic [1:0] CH_PRESENT = (N_CH == 2) ? 2'h3 : 2'h1;

    // two-flop synchroniser, first stage read only by the second
    ldm_pkg::ldm_flags_t sync_a;
    ldm_pkg::ldm_flags_t flg;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sync_a <= '0;
            flg <= '0;
        end else begin
            sync_a <= i_flags;
            flg <= sync_a;
        end
    end

    logic [1:0] on_q;
    logic [1:0] off_q;
    logic [1:0] ch_fail;
    logic [1:0] off_seen;
    logic [1:0] fail_det;
    ldm_pkg::ldm_state_t state;
    ldm_pkg::ldm_state_t next_state;
    logic [31:0] ctrl;
    logic [`LDM_IRQ_W-1:0] irq_stat;
    logic [`LDM_IRQ_W-1:0] irq_mask;
    logic [`LDM_IRQ_W-1:0] irq_ev;
    logic active;
    logic all_off;
    logic any_on;

    assign all_off = &(off_q | ~CH_PRESENT);
    assign any_on = |(on_q & CH_PRESENT);
    assign active = (state == ldm_pkg::ST_ON) || (state == ldm_pkg::ST_LOW_V);

    // per-channel qualification and fail latch
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic [CNT_W-1:0] qcnt;
        logic last_lvl;
        logic present;
        assign present = CH_PRESENT[c];

        // counter restarts on each level change and saturates
        always_ff @(posedge i_sys_clk) begin
            if (i_rst) begin
                qcnt <= '0;
                last_lvl <= 1'b0;
            end else if (flg.dimming_input[c] != last_lvl) begin
                qcnt <= '0;
                last_lvl <= flg.dimming_input[c];
            end else if (qcnt != {CNT_W{1'b1}}) begin
                qcnt <= qcnt + CNT_W'(1);
            end
        end
        // "longer than" the time: strictly past the count
        assign on_q[c] = present && last_lvl && (qcnt > ON_Q);
        assign off_q[c] = present && !last_lvl && (qcnt > OFF_Q);

        assign fail_det[c] = present && active &&
            (flg.vout_low[c] || flg.sense_cm_low[c] || flg.sense_short[c]);

        // latched until this channel is qualified off then on
        always_ff @(posedge i_sys_clk) begin
            if (i_rst) begin
                ch_fail[c] <= 1'b0;
                off_seen[c] <= 1'b0;
            end else if (fail_det[c]) begin
                ch_fail[c] <= 1'b1;
                off_seen[c] <= 1'b0;
            end else if (ch_fail[c] && off_q[c]) begin
                off_seen[c] <= 1'b1;
            end else if (ch_fail[c] && off_seen[c] && on_q[c]) begin
                ch_fail[c] <= 1'b0;
                off_seen[c] <= 1'b0;
            end
        end

        // analog drive for this channel
        assign o_drive.dim_switch_on[c] = active && !ch_fail[c] && !fail_det[c] &&
            flg.dimming_input[c];
        assign o_drive.boost_en[c] = (state == ldm_pkg::ST_ON) && !ch_fail[c];
        assign o_drive.comp_hold[c] = !(o_drive.dim_switch_on[c] && o_drive.boost_en[c]);
        // held value is kept across dimming; only cleared outside operation
        assign o_drive.comp_clear[c] = !active;
        assign o_drive.diag_drive_high[c] = present && ch_fail[c] &&
            (state != ldm_pkg::ST_SHUTDOWN);
        // shutdown pulls both low; a failure stays latched underneath until its cycle
        assign o_drive.diag_drive_low[c] = present && ((state == ldm_pkg::ST_SHUTDOWN) ||
            (active && !ch_fail[c] && flg.open_load[c]));
    end

    assign o_drive.vreg_en = (state != ldm_pkg::ST_STANDBY);

    // global state transitions, undervoltage first
    always_comb begin
        next_state = state;
        unique case (state)
            ldm_pkg::ST_STANDBY: begin
                if (flg.supply_above_6v && any_on) next_state = ldm_pkg::ST_ON;
            end
            ldm_pkg::ST_ON, ldm_pkg::ST_LOW_V: begin
                if (flg.supply_below_3v5) next_state = ldm_pkg::ST_STANDBY;
                else if (flg.supply_above_40v) next_state = ldm_pkg::ST_OVERVOLT;
                else if (flg.temp_above_165c) next_state = ldm_pkg::ST_OVERTEMP;
                else if (all_off) next_state = ldm_pkg::ST_SHUTDOWN;
                else if (flg.supply_below_4v) next_state = ldm_pkg::ST_LOW_V;
                else next_state = ldm_pkg::ST_ON;
            end
            ldm_pkg::ST_OVERVOLT: begin
                if (flg.supply_below_3v5) next_state = ldm_pkg::ST_STANDBY;
                else if (!flg.supply_above_40v && all_off) next_state = ldm_pkg::ST_SHUTDOWN;
            end
            ldm_pkg::ST_OVERTEMP: begin
                if (flg.supply_below_3v5) next_state = ldm_pkg::ST_STANDBY;
                else if (flg.temp_below_145c && ctrl[`LDM_CTRL_OT_AUTO]) begin
                    next_state = ldm_pkg::ST_ON;
                end else if (flg.temp_below_145c && all_off) begin
                    next_state = ldm_pkg::ST_SHUTDOWN;
                end
            end
            ldm_pkg::ST_SHUTDOWN: begin
                if (flg.supply_below_3v5) next_state = ldm_pkg::ST_STANDBY;
                else if (!flg.supply_above_40v && !flg.temp_above_165c && any_on) begin
                    next_state = ldm_pkg::ST_ON;
                end
            end
            default: next_state = ldm_pkg::ST_STANDBY;
        endcase
    end

    // state register
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) state <= ldm_pkg::ST_STANDBY;
        else state <= next_state;
    end

    // events entering overvoltage, overtemperature, standby or shutdown, or failing a channel
    always_comb begin
        irq_ev = '0;
        irq_ev[`LDM_IRQ_FAIL0] = fail_det[0] && !ch_fail[0];
        irq_ev[`LDM_IRQ_FAIL1] = fail_det[1] && !ch_fail[1];
        irq_ev[`LDM_IRQ_OV] = (next_state == ldm_pkg::ST_OVERVOLT) &&
            (state != ldm_pkg::ST_OVERVOLT);
        irq_ev[`LDM_IRQ_OT] = (next_state == ldm_pkg::ST_OVERTEMP) &&
            (state != ldm_pkg::ST_OVERTEMP);
        irq_ev[`LDM_IRQ_STANDBY] = (next_state == ldm_pkg::ST_STANDBY) &&
            (state != ldm_pkg::ST_STANDBY);
        irq_ev[`LDM_IRQ_SHUTDOWN] = (next_state == ldm_pkg::ST_SHUTDOWN) &&
            (state != ldm_pkg::ST_SHUTDOWN);
    end

    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~((i_wr && i_addr == `LDM_REG_IRQ_STAT) ?
                i_wdata[`LDM_IRQ_W-1:0] : '0)) | irq_ev;
        end
    end

    // control and mask registers
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ctrl <= `LDM_CTRL_RESET;
            irq_mask <= `LDM_IRQ_MASK_RESET;
        end else if (i_wr) begin
            if (i_addr == `LDM_REG_CTRL) ctrl <= {31'h0000_0000, i_wdata[`LDM_CTRL_OT_AUTO]};
            if (i_addr == `LDM_REG_IRQ_MASK) irq_mask <= i_wdata[`LDM_IRQ_W-1:0];
        end
    end

    assign o_irq = |(irq_stat & irq_mask);

    // read data registered, standing only in the cycle after the strobe
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || !i_rd) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            unique case (i_addr)
                `LDM_REG_STATUS: o_rdata <= {22'h00_0000, o_drive.dim_switch_on,
                    o_drive.boost_en, ch_fail, 1'b0, state};
                `LDM_REG_CTRL: o_rdata <= ctrl;
                `LDM_REG_IRQ_STAT: o_rdata <= {26'h000_0000, irq_stat};
                `LDM_REG_IRQ_MASK: o_rdata <= {26'h000_0000, irq_mask};
                default: o_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // checks
    property p_sw_follow;
        @(posedge i_sys_clk) disable iff (i_rst)
        o_drive.dim_switch_on[0] |-> flg.dimming_input[0] && active && !ch_fail[0];
    endproperty
    a_sw_follow: assert property (p_sw_follow) else $error("switch on without input");

    property p_hold;
        @(posedge i_sys_clk) disable iff (i_rst)
        !o_drive.dim_switch_on[0] |-> o_drive.comp_hold[0];
    endproperty
    a_hold: assert property (p_hold) else $error("loop not frozen while switch off");

    property p_resume;
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == ldm_pkg::ST_ON) && $rose(o_drive.dim_switch_on[0]) |-> !o_drive.comp_clear[0];
    endproperty
    a_resume: assert property (p_resume) else $error("compensation cleared at on-time");

    property p_uv4;
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == ldm_pkg::ST_LOW_V) |-> o_drive.boost_en == 2'b00 && o_drive.vreg_en;
    endproperty
    a_uv4: assert property (p_uv4) else $error("boost on in low-voltage state");

    property p_standby;
        @(posedge i_sys_clk) disable iff (i_rst)
        active && flg.supply_below_3v5 |=> state == ldm_pkg::ST_STANDBY;
    endproperty
    a_standby: assert property (p_standby) else $error("no standby on undervoltage");

    property p_wake;
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == ldm_pkg::ST_STANDBY) && !(flg.supply_above_6v && any_on)
            |=> state == ldm_pkg::ST_STANDBY;
    endproperty
    a_wake: assert property (p_wake) else $error("standby left without wake");

    property p_ov;
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == ldm_pkg::ST_OVERVOLT) |-> o_drive.dim_switch_on == 2'b00 &&
            o_drive.boost_en == 2'b00 && o_drive.vreg_en;
    endproperty
    a_ov: assert property (p_ov) else $error("drive active in overvoltage");

    property p_ov_exit;
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == ldm_pkg::ST_OVERVOLT) ##1 (state != ldm_pkg::ST_OVERVOLT)
            |-> $past(all_off) || $past(flg.supply_below_3v5);
    endproperty
    a_ov_exit: assert property (p_ov_exit) else $error("overvoltage left without cycle");

    property p_ot;
        @(posedge i_sys_clk) disable iff (i_rst)
        active && flg.temp_above_165c && !flg.supply_below_3v5 && !flg.supply_above_40v
            |=> state == ldm_pkg::ST_OVERTEMP ##0 o_drive.dim_switch_on == 2'b00;
    endproperty
    a_ot: assert property (p_ot) else $error("overtemperature not entered");

    property p_fail;
        @(posedge i_sys_clk) disable iff (i_rst)
        fail_det[0] |=> ch_fail[0] && !o_drive.dim_switch_on[0] &&
            (o_drive.diag_drive_high[0] || state == ldm_pkg::ST_SHUTDOWN);
    endproperty
    a_fail: assert property (p_fail) else $error("channel failure not latched");

    property p_shut_diag;
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == ldm_pkg::ST_SHUTDOWN) |-> o_drive.diag_drive_low == CH_PRESENT &&
            o_drive.diag_drive_high == 2'b00;
    endproperty
    a_shut_diag: assert property (p_shut_diag) else $error("diagnostic not low in shutdown");

    property p_lowv;
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == ldm_pkg::ST_LOW_V) && flg.dimming_input[0] && !ch_fail[0] && !fail_det[0]
            |-> o_drive.dim_switch_on[0] && o_drive.vreg_en;
    endproperty
    a_lowv: assert property (p_lowv) else $error("switch lost in low-voltage state");

    property p_recover;
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == ldm_pkg::ST_LOW_V) && !flg.supply_below_4v && !flg.supply_below_3v5 &&
            !flg.supply_above_40v && !flg.temp_above_165c && !all_off
            |=> state == ldm_pkg::ST_ON;
    endproperty
    a_recover: assert property (p_recover) else $error("no recovery from low voltage");

    property p_ot_exit;
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == ldm_pkg::ST_OVERTEMP) ##1 (state != ldm_pkg::ST_OVERTEMP)
            |-> $past(flg.temp_below_145c) || $past(flg.supply_below_3v5);
    endproperty
    a_ot_exit: assert property (p_ot_exit) else $error("overtemperature left while hot");

    property p_open;
        @(posedge i_sys_clk) disable iff (i_rst)
        active && flg.open_load[0] && !ch_fail[0]
            |-> o_drive.diag_drive_low[0] && !o_drive.diag_drive_high[0];
    endproperty
    a_open: assert property (p_open) else $error("open load not reported low");

    property p_detect;
        @(posedge i_sys_clk) disable iff (i_rst)
        active && (flg.vout_low[0] || flg.sense_cm_low[0] || flg.sense_short[0])
            |-> !o_drive.dim_switch_on[0];
    endproperty
    a_detect: assert property (p_detect) else $error("switch on during output fault");

    property p_qual;
        @(posedge i_sys_clk) disable iff (i_rst)
        $changed(flg.dimming_input[0]) |=> !on_q[0] && !off_q[0];
    endproperty
    a_qual: assert property (p_qual) else $error("qualification not restarted");

endmodule

// ===== sim/ldm_mcu_model.sv
module ldm_mcu_model (
    input wire logic i_sys_clk,
    input wire logic [1:0] i_level,
    input wire logic [1:0] i_diag_high,
    output logic [1:0] o_dimming_input = 2'b00,
    output logic o_fault_seen
);
    timeunit 1ns;
    timeprecision 1ps;

    // pins move only on the clock edge, so every pulse is a whole count of cycles
    always @(posedge i_sys_clk) begin
        o_dimming_input <= i_level;
    end

    // a high diagnostic means a latched channel failure
    assign o_fault_seen = |i_diag_high;
endmodule

// ===== sim/test_led_driver_mode_fault_fsm.sv
`include "ldm_map.svh"

module test_led_driver_mode_fault_fsm;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic irq;
    logic [1:0] dim_cmd = 2'b00;
    logic [1:0] dim_pin;
    logic [2:0] cause = 3'b000;
    logic fault_seen;
    ldm_pkg::ldm_flags_t fl = '0;
    ldm_pkg::ldm_flags_t flags_in;
    ldm_pkg::ldm_drive_t drv;
    logic [31:0] d;
    logic [3:0] ra [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
    int failures = 0;
    int num_checks = 0;

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // pins come from the controller model, fault causes from one small vector
    always_comb begin
        flags_in = fl;
        flags_in.dimming_input = dim_pin;
        flags_in.vout_low[0] = cause[0];
        flags_in.sense_cm_low[0] = cause[1];
        flags_in.sense_short[0] = cause[2];
    end

    // short counts keep the run brief; off count longer so short gaps never qualify
    ldm_fsm #(.N_CH(2), .CNT_W(12), .ON_QUAL(4), .OFF_QUAL(8)) u_dut (
        .i_sys_clk(clk), .i_rst(rst), .i_flags(flags_in), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
        .o_drive(drv));

    ldm_mcu_model u_mcu (.i_sys_clk(clk), .i_level(dim_cmd),
        .i_diag_high(drv.diag_drive_high), .o_dimming_input(dim_pin),
        .o_fault_seen(fault_seen));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic wait_state(input ldm_pkg::ldm_state_t st);
        int n;
        n = 0;
        reg_rd(`LDM_REG_STATUS);
        while (d[2:0] !== st && n < 40) begin
            reg_rd(`LDM_REG_STATUS);
            n++;
        end
        chk("state", 32'(st), 32'(d[2:0]));
    endtask

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // cut a hang short well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish;
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        reg_wr(4'hF, 32'hFFFF_FFFF);
        for (int i = 0; i < 4; i++) begin
            reg_rd(ra[i]);
            chk("reset read", 32'h0, d);
        end
        @(posedge clk);
        fl.supply_above_6v <= 1'b1;
        dim_cmd <= 2'b01;
        wait_state(ldm_pkg::ST_ON);
        chk("boost", 32'h3, 32'(drv.boost_en));
        chk("switch", 32'h1, 32'(drv.dim_switch_on));
        @(posedge clk);
        dim_cmd <= 2'b00;
        tick(4);
        chk("switch", 32'h0, 32'(drv.dim_switch_on));
        chk("hold", 32'h1, 32'(drv.comp_hold[0]));
        @(posedge clk);
        dim_cmd <= 2'b01;
        tick(4);
        chk("switch", 32'h1, 32'(drv.dim_switch_on));
        chk("hold", 32'h0, 32'(drv.comp_hold[0]));
        chk("clear", 32'h0, 32'(drv.comp_clear[0]));
        @(posedge clk);
        fl.supply_below_4v <= 1'b1;
        wait_state(ldm_pkg::ST_LOW_V);
        chk("boost", 32'h0, 32'(drv.boost_en));
        chk("switch", 32'h1, 32'(drv.dim_switch_on));
        chk("vreg", 32'h1, 32'(drv.vreg_en));
        @(posedge clk);
        fl.supply_below_4v <= 1'b0;
        wait_state(ldm_pkg::ST_ON);
        chk("boost", 32'h3, 32'(drv.boost_en));
        @(posedge clk);
        fl.open_load[0] <= 1'b1;
        tick(4);
        chk("diag low", 32'h1, 32'(drv.diag_drive_low[0]));
        chk("switch", 32'h1, 32'(drv.dim_switch_on));
        @(posedge clk);
        fl.open_load[0] <= 1'b0;
        reg_wr(`LDM_REG_IRQ_MASK, 32'h1);
        // each of the three causes, then the channel off-on cycle that clears it
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            cause <= 3'(1 << i);
            tick(5);
            chk("diag high", 32'h1, 32'(drv.diag_drive_high[0]));
            chk("fault seen", 32'h1, 32'(fault_seen));
            chk("switch", 32'h0, 32'(drv.dim_switch_on));
            chk("irq", 32'h1, 32'(irq));
            @(posedge clk);
            cause <= 3'b000;
            tick(6);
            chk("latched", 32'h1, 32'(drv.diag_drive_high[0]));
            @(posedge clk);
            dim_cmd <= 2'b00;
            wait_state(ldm_pkg::ST_SHUTDOWN);
            chk("diag low", 32'h3, 32'(drv.diag_drive_low));
            chk("fault seen", 32'h0, 32'(fault_seen));
            @(posedge clk);
            dim_cmd <= 2'b01;
            wait_state(ldm_pkg::ST_ON);
            chk("fail bits", 32'h0, 32'(d[5:4]));
            reg_rd(`LDM_REG_IRQ_STAT);
            chk("stat fail0", 32'h1, 32'(d[0]));
            reg_wr(`LDM_REG_IRQ_STAT, 32'h3F);
            tick(1);
            chk("irq clear", 32'h0, 32'(irq));
        end
        @(posedge clk);
        fl.supply_above_40v <= 1'b1;
        wait_state(ldm_pkg::ST_OVERVOLT);
        chk("boost", 32'h0, 32'(drv.boost_en));
        chk("switch", 32'h0, 32'(drv.dim_switch_on));
        chk("vreg", 32'h1, 32'(drv.vreg_en));
        chk("irq masked", 32'h0, 32'(irq));
        @(posedge clk);
        fl.supply_above_40v <= 1'b0;
        tick(20);
        wait_state(ldm_pkg::ST_OVERVOLT);
        @(posedge clk);
        dim_cmd <= 2'b00;
        wait_state(ldm_pkg::ST_SHUTDOWN);
        @(posedge clk);
        dim_cmd <= 2'b10;
        wait_state(ldm_pkg::ST_ON);
        reg_wr(`LDM_REG_CTRL, 32'h1);
        reg_rd(`LDM_REG_CTRL);
        chk("ctrl", 32'h1, d);
        @(posedge clk);
        fl.temp_above_165c <= 1'b1;
        wait_state(ldm_pkg::ST_OVERTEMP);
        chk("boost", 32'h0, 32'(drv.boost_en));
        chk("switch", 32'h0, 32'(drv.dim_switch_on));
        chk("clear", 32'h3, 32'(drv.comp_clear));
        @(posedge clk);
        fl.temp_above_165c <= 1'b0;
        tick(20);
        wait_state(ldm_pkg::ST_OVERTEMP);
        @(posedge clk);
        fl.temp_below_145c <= 1'b1;
        wait_state(ldm_pkg::ST_ON);
        // without automatic recovery, cooling alone must not restart the channels
        reg_wr(`LDM_REG_CTRL, 32'h0);
        @(posedge clk);
        fl.temp_below_145c <= 1'b0;
        fl.temp_above_165c <= 1'b1;
        wait_state(ldm_pkg::ST_OVERTEMP);
        @(posedge clk);
        fl.temp_above_165c <= 1'b0;
        fl.temp_below_145c <= 1'b1;
        tick(20);
        wait_state(ldm_pkg::ST_OVERTEMP);
        @(posedge clk);
        dim_cmd <= 2'b00;
        wait_state(ldm_pkg::ST_SHUTDOWN);
        @(posedge clk);
        dim_cmd <= 2'b10;
        wait_state(ldm_pkg::ST_ON);
        @(posedge clk);
        fl.supply_below_4v <= 1'b1;
        fl.supply_below_3v5 <= 1'b1;
        wait_state(ldm_pkg::ST_STANDBY);
        tally_and_finish;
    end
endmodule
